// File: src/pmwc_power_mode_wakeup_control.sv
`timescale 1ns/1ps
module pmwc_power_mode_wakeup_control #(
    parameter int PORT_W = 8,
    parameter int IRQ_W = 8,
    parameter int LXT_WAIT = pmwc_pkg::LXT_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // cpu core
    input wire logic halt_exec,
    input wire logic clear_wdt_exec,
    input wire logic [IRQ_W-1:0] irq_request,
    input wire logic [IRQ_W-1:0] irq_enable,
    input wire logic stack_full,
    input wire logic wdt_overflow,
    output logic cpu_halted,
    output logic resume_after_halt,
    output logic irq_vector_take,
    output logic pc_sp_reset,
    // port pins
    input wire logic [PORT_W-1:0] port_pins,
    // oscillators
    input wire logic sub_is_crystal,
    output logic high_osc_enable,
    output logic high_div_taps_enable,
    output logic sub_clk_enable,
    output logic sys_clk_enable,
    output logic time_base_clk_enable,
    output logic wdt_clk_enable,
    output logic wdt_counter_clear,
    output logic sys_clk_is_sub,
    output logic [2:0] high_div_log2
);
    // configuration and status
    logic [2:0] clock_divider_select_reg;
    logic high_clock_select_reg, idle_enable_reg, idle_sysclk_keep_running_reg;
    logic low_voltage_detector_enable_reg, wdt_enable_reg;
    logic [PORT_W-1:0] port_wake_enable_reg;
    logic power_down_flag_reg, watchdog_timeout_flag_reg;
    logic high_speed_ready_flag_reg, low_speed_ready_flag_reg;
    logic [10:0] lrdy_cnt_reg;
    logic [4:0] hrdy_cnt_reg;
    logic sub_active_reg;
    pmwc_pkg::pmwc_mode_e mode_reg, mode_next;
    logic [IRQ_W-1:0] irq_armed_reg;
    logic [PORT_W-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;

    // sub-clock requested by divider field while high clock select is clear
    function automatic logic sub_code(input logic hl, input logic [2:0] cks);
        sub_code = !hl && (cks[2:1] == 2'b00);
    endfunction : sub_code

    wire want_sub = sub_code(high_clock_select_reg, clock_divider_select_reg);
    wire in_low_power = (mode_reg != pmwc_pkg::PMWC_RUN);
    wire port_fall = |(pin_s3_reg & ~pin_s2_reg & port_wake_enable_reg);
    wire [IRQ_W-1:0] irq_wake_vec = irq_request & irq_armed_reg;
    wire irq_wake = |irq_wake_vec;
    wire irq_serviceable = |(irq_wake_vec & irq_enable) && !stack_full;
    wire wake = in_low_power && (port_fall || irq_wake || wdt_overflow);
    wire sleep_ok = !(low_voltage_detector_enable_reg || wdt_enable_reg);

    // mode decision on halt
    always_comb begin
        mode_next = mode_reg;
        if (!in_low_power && halt_exec) begin
            if (idle_enable_reg) begin
                mode_next = idle_sysclk_keep_running_reg ? pmwc_pkg::PMWC_CLK_RUNNING_WAIT
                                                         : pmwc_pkg::PMWC_CLK_STOPPED_WAIT;
            end else if (sleep_ok) begin
                mode_next = pmwc_pkg::PMWC_DEEP_STOP;
            end else begin
                mode_next = pmwc_pkg::PMWC_LIGHT_STOP;
            end
        end else if (wake) begin
            mode_next = pmwc_pkg::PMWC_RUN;
        end
    end

    wire entering = !in_low_power && halt_exec;
    wire high_stopped = (mode_next == pmwc_pkg::PMWC_DEEP_STOP) || (mode_next == pmwc_pkg::PMWC_LIGHT_STOP)
        || (mode_next == pmwc_pkg::PMWC_CLK_STOPPED_WAIT);
    wire sub_select_done = want_sub && low_speed_ready_flag_reg;
    wire [2:0] div_log2 = 3'h7 - clock_divider_select_reg + 3'h1;

    // axi4-lite slave
    logic aw_hold_reg, w_hold_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    wire do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    wire wr_mode = do_write && (aw_addr_reg == pmwc_pkg::MODE_OFFSET) && w_strb_reg[0];
    wire wr_ctrl = do_write && (aw_addr_reg == pmwc_pkg::CTRL_OFFSET) && w_strb_reg[0];
    wire wr_wake = do_write && (aw_addr_reg == pmwc_pkg::WAKE_OFFSET) && w_strb_reg[0];
    wire wr_known = (aw_addr_reg == pmwc_pkg::MODE_OFFSET) || (aw_addr_reg == pmwc_pkg::CTRL_OFFSET)
        || (aw_addr_reg == pmwc_pkg::WAKE_OFFSET) || (aw_addr_reg == pmwc_pkg::STATUS_OFFSET);
    wire [31:0] mode_word = {24'h0, clock_divider_select_reg, 1'b0, low_speed_ready_flag_reg,
        high_speed_ready_flag_reg, idle_enable_reg, high_clock_select_reg};
    wire [31:0] ctrl_word = {24'h0, idle_sysclk_keep_running_reg, 5'h0, wdt_enable_reg,
        low_voltage_detector_enable_reg};
    wire [31:0] wake_word = {{(32-PORT_W){1'b0}}, port_wake_enable_reg};
    wire [31:0] stat_word = {25'h0, mode_reg, 2'h0, watchdog_timeout_flag_reg, power_down_flag_reg};
    wire rd_take = s_axi_arvalid && s_axi_arready;
    logic [31:0] rd_word;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        if (s_axi_araddr == pmwc_pkg::MODE_OFFSET) begin
            rd_word = mode_word;
        end else if (s_axi_araddr == pmwc_pkg::CTRL_OFFSET) begin
            rd_word = ctrl_word;
        end else if (s_axi_araddr == pmwc_pkg::WAKE_OFFSET) begin
            rd_word = wake_word;
        end else if (s_axi_araddr == pmwc_pkg::STATUS_OFFSET) begin
            rd_word = stat_word;
        end else begin
            rd_word = 32'h0;
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pmwc_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= pmwc_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? pmwc_pkg::RESP_OKAY : pmwc_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? pmwc_pkg::RESP_OKAY : pmwc_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // configuration registers; entry changes none of them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_divider_select_reg <= pmwc_pkg::CKS_RESET;
            high_clock_select_reg <= pmwc_pkg::HIGH_CLOCK_SELECT_RESET;
            idle_enable_reg <= pmwc_pkg::IDLE_ENABLE_RESET;
            idle_sysclk_keep_running_reg <= pmwc_pkg::KEEP_RESET;
            low_voltage_detector_enable_reg <= 1'b0;
            wdt_enable_reg <= 1'b1;
            port_wake_enable_reg <= '0;
        end else begin
            if (wr_mode) begin
                clock_divider_select_reg <= w_data_reg[pmwc_pkg::CKS_LSB +: 3];
                high_clock_select_reg <= w_data_reg[pmwc_pkg::HIGH_CLOCK_SELECT_BIT];
                idle_enable_reg <= w_data_reg[pmwc_pkg::IDLE_ENABLE_BIT];
            end
            if (wr_ctrl) begin
                idle_sysclk_keep_running_reg <= w_data_reg[pmwc_pkg::KEEP_BIT];
                low_voltage_detector_enable_reg <= w_data_reg[pmwc_pkg::LOW_VOLTAGE_DETECTOR_ENABLE_BIT];
                wdt_enable_reg <= w_data_reg[pmwc_pkg::WDTEN_BIT];
            end
            if (wr_wake) begin
                port_wake_enable_reg <= w_data_reg[PORT_W-1:0];
            end
        end
    end

    // mode, flags, wake detection on the free-running clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= pmwc_pkg::PMWC_RUN;
            power_down_flag_reg <= 1'b0;
            watchdog_timeout_flag_reg <= 1'b0;
            irq_armed_reg <= '0;
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
        end else begin
            mode_reg <= mode_next;
            pin_s1_reg <= port_pins;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            if (entering) begin
                irq_armed_reg <= ~irq_request;
            end
            if (entering) begin
                power_down_flag_reg <= 1'b1;
            end else if (clear_wdt_exec) begin
                power_down_flag_reg <= 1'b0;
            end
            if (in_low_power && wdt_overflow) begin
                watchdog_timeout_flag_reg <= 1'b1;
            end else if (entering) begin
                watchdog_timeout_flag_reg <= 1'b0;
            end
        end
    end

    // ready flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            high_speed_ready_flag_reg <= 1'b0;
            hrdy_cnt_reg <= 5'h0;
            low_speed_ready_flag_reg <= 1'b0;
            lrdy_cnt_reg <= 11'h0;
            sub_active_reg <= 1'b0;
        end else begin
            if (high_stopped || (want_sub && sub_active_reg)) begin
                high_speed_ready_flag_reg <= 1'b0;
                hrdy_cnt_reg <= 5'h0;
            end else if (!high_speed_ready_flag_reg) begin
                hrdy_cnt_reg <= hrdy_cnt_reg + 5'h1;
                if (hrdy_cnt_reg == 5'(pmwc_pkg::HRDY_MIN_CYCLES - 1)) begin
                    high_speed_ready_flag_reg <= 1'b1;
                end
            end
            if (mode_next == pmwc_pkg::PMWC_DEEP_STOP) begin
                low_speed_ready_flag_reg <= 1'b0;
                lrdy_cnt_reg <= 11'h0;
            end else if (!low_speed_ready_flag_reg) begin
                lrdy_cnt_reg <= lrdy_cnt_reg + 11'h1;
                if (lrdy_cnt_reg == (sub_is_crystal ? 11'(LXT_WAIT - 1) : 11'(pmwc_pkg::LOW_SPEED_INTERNAL_OSC_CYCLES - 1))) begin
                    low_speed_ready_flag_reg <= 1'b1;
                end
            end
            sub_active_reg <= want_sub ? (sub_active_reg || sub_select_done) : 1'b0;
        end
    end

    // clock gating and cpu answers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            high_osc_enable <= 1'b1;
            high_div_taps_enable <= 1'b1;
            sub_clk_enable <= 1'b1;
            sys_clk_enable <= 1'b1;
            time_base_clk_enable <= 1'b1;
            wdt_clk_enable <= 1'b1;
            wdt_counter_clear <= 1'b0;
            sys_clk_is_sub <= 1'b0;
            high_div_log2 <= 3'h0;
            cpu_halted <= 1'b0;
            resume_after_halt <= 1'b0;
            irq_vector_take <= 1'b0;
            pc_sp_reset <= 1'b0;
        end else begin
            high_osc_enable <= !(sub_active_reg || high_stopped);
            high_div_taps_enable <= !(sub_active_reg || high_stopped);
            sys_clk_is_sub <= sub_active_reg;
            high_div_log2 <= high_clock_select_reg ? 3'h0 : div_log2;
            sys_clk_enable <= (mode_next == pmwc_pkg::PMWC_RUN) || (mode_next == pmwc_pkg::PMWC_CLK_RUNNING_WAIT);
            time_base_clk_enable <= (mode_next == pmwc_pkg::PMWC_RUN) || (mode_next == pmwc_pkg::PMWC_CLK_RUNNING_WAIT)
                || (mode_next == pmwc_pkg::PMWC_CLK_STOPPED_WAIT);
            sub_clk_enable <= (mode_next != pmwc_pkg::PMWC_DEEP_STOP) || low_voltage_detector_enable_reg;
            wdt_clk_enable <= (mode_next != pmwc_pkg::PMWC_DEEP_STOP) && wdt_enable_reg;
            wdt_counter_clear <= entering || clear_wdt_exec;
            cpu_halted <= (mode_next != pmwc_pkg::PMWC_RUN);
            resume_after_halt <= wake && !wdt_overflow && !irq_serviceable;
            irq_vector_take <= wake && !wdt_overflow && !port_fall && irq_serviceable;
            pc_sp_reset <= wake && wdt_overflow;
        end
    end

    a_deep_clocks: assert property (@(posedge aclk) disable iff (!aresetn)
        (entering && !idle_enable_reg && sleep_ok) |=> !sys_clk_enable && !wdt_clk_enable && !time_base_clk_enable)
        else $error("deep stop left a clock running");
    a_pdf_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        entering |=> power_down_flag_reg && !watchdog_timeout_flag_reg)
        else $error("entry flags wrong");
    a_to_overflow: assert property (@(posedge aclk) disable iff (!aresetn)
        (in_low_power && wdt_overflow) |=> watchdog_timeout_flag_reg ##0 pc_sp_reset)
        else $error("watchdog wake did not flag");
    a_lvd_no_deep: assert property (@(posedge aclk) disable iff (!aresetn)
        low_voltage_detector_enable_reg |-> mode_reg != pmwc_pkg::PMWC_DEEP_STOP || $past(entering) == 1'b0)
        else $error("deep stop with detector on");
    a_hrdy_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(high_speed_ready_flag_reg) |-> $past(!high_speed_ready_flag_reg, 15))
        else $error("high ready too early");
    a_idle_run: assert property (@(posedge aclk) disable iff (!aresetn)
        (entering && idle_enable_reg && idle_sysclk_keep_running_reg) |=> sys_clk_enable && cpu_halted)
        else $error("running wait stopped clock");
    a_sub_after_ready: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(sub_active_reg) |-> $past(low_speed_ready_flag_reg))
        else $error("slow switch before ready");
    a_port_wake: assert property (@(posedge aclk) disable iff (!aresetn)
        (wake && port_fall && !wdt_overflow) |=> !pc_sp_reset && !irq_vector_take ##1 mode_reg == pmwc_pkg::PMWC_RUN)
        else $error("port wake misrouted");
endmodule : pmwc_power_mode_wakeup_control

// File: src/pmwc_pkg.sv
package pmwc_pkg;
    // register byte offsets
    localparam logic [7:0] MODE_OFFSET = 8'h00;
    localparam logic [7:0] CTRL_OFFSET = 8'h04;
    localparam logic [7:0] WAKE_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0C;
    // mode register fields
    localparam int HIGH_CLOCK_SELECT_BIT = 0;
    localparam int IDLE_ENABLE_BIT = 1;
    localparam int HRDY_BIT = 2;
    localparam int LRDY_BIT = 3;
    localparam int CKS_LSB = 5;
    // control register fields
    localparam int KEEP_BIT = 7;
    localparam int LOW_VOLTAGE_DETECTOR_ENABLE_BIT = 0;
    localparam int WDTEN_BIT = 1;
    // status register fields
    localparam int PDF_BIT = 0;
    localparam int TO_BIT = 1;
    localparam int MODE_LSB = 4;
    // reset values
    localparam logic [2:0] CKS_RESET = 3'h0;
    localparam logic HIGH_CLOCK_SELECT_RESET = 1'b1;
    localparam logic IDLE_ENABLE_RESET = 1'b1;
    localparam logic KEEP_RESET = 1'b0;
    // timing counts in cycles
    localparam int HRDY_MIN_CYCLES = 15;
    localparam int LXT_CYCLES = 1024;
    localparam int LOW_SPEED_INTERNAL_OSC_CYCLES = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        PMWC_RUN = 3'b000,
        PMWC_DEEP_STOP = 3'b001,
        PMWC_LIGHT_STOP = 3'b010,
        PMWC_CLK_STOPPED_WAIT = 3'b011,
        PMWC_CLK_RUNNING_WAIT = 3'b100
    } pmwc_mode_e;
endpackage : pmwc_pkg

// File: verif/pmwc_cpu_model.sv
`timescale 1ns/1ps
module pmwc_cpu_model (
    // clock
    input wire logic aclk,
    // wake answers and watchdog counter clear from the controller
    input wire logic resume_after_halt,
    input wire logic irq_vector_take,
    input wire logic pc_sp_reset,
    input wire logic wdt_counter_clear,
    // instruction strobes
    output logic halt_exec,
    output logic clear_wdt_exec
);
    int resume_cnt = 0;
    int vector_cnt = 0;
    int pcsp_cnt = 0;
    int clr_cnt = 0;
    initial begin
        halt_exec = 1'b0;
        clear_wdt_exec = 1'b0;
    end
    // answers are one-cycle pulses, so count them at the edge they stand on
    always @(posedge aclk) begin
        resume_cnt <= resume_cnt + int'(resume_after_halt);
        vector_cnt <= vector_cnt + int'(irq_vector_take);
        pcsp_cnt <= pcsp_cnt + int'(pc_sp_reset);
        clr_cnt <= clr_cnt + int'(wdt_counter_clear);
    end
    task automatic run_halt();
        @(posedge aclk);
        halt_exec <= 1'b1;
        @(posedge aclk);
        halt_exec <= 1'b0;
    endtask : run_halt
    task automatic run_clear();
        @(posedge aclk);
        clear_wdt_exec <= 1'b1;
        @(posedge aclk);
        clear_wdt_exec <= 1'b0;
    endtask : run_clear
endmodule : pmwc_cpu_model

// File: verif/power_mode_wakeup_control_tb.sv
`timescale 1ns/1ps
module power_mode_wakeup_control_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic halt_exec, clear_wdt_exec;
    logic [7:0] irq_request = 8'h00, irq_enable = 8'h00, port_pins = 8'hFF;
    logic stack_full = 1'b0, wdt_overflow = 1'b0, sub_is_crystal = 1'b0;
    logic cpu_halted, resume_after_halt, irq_vector_take, pc_sp_reset, wdt_counter_clear, sys_clk_is_sub;
    logic high_osc_enable, high_div_taps_enable, sub_clk_enable, sys_clk_enable, time_base_clk_enable, wdt_clk_enable;
    logic [2:0] high_div_log2;
    int mismatches = 0, check_count = 0, cycles = 0;
    // short ready count keeps the run brief
    pmwc_power_mode_wakeup_control #(.LXT_WAIT(16)) i_pmwc_power_mode_wakeup_control (.*);
    pmwc_cpu_model i_pmwc_cpu_model (.*);
    always #25 aclk = ~aclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        check(s_axi_bresp, pmwc_pkg::RESP_OKAY);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(d & m, exp);
    endtask : rchk
    task automatic port_fall(input int p);
        @(posedge aclk);
        port_pins <= ~(8'h01 << p);
        repeat (4) @(posedge aclk);
        port_pins <= 8'hFF;
    endtask : port_fall
    task automatic wait_wake();
        int n;
        n = 0;
        while (cpu_halted !== 1'b0 && n < 60) begin
            @(posedge aclk);
            n++;
        end
        @(posedge aclk);
        check(cpu_halted, 1'b0);
    endtask : wait_wake
    task automatic test_regs();
        logic [31:0] d;
        logic [1:0] r;
        rchk(pmwc_pkg::MODE_OFFSET, 32'hE3, 32'h03);
        rchk(pmwc_pkg::CTRL_OFFSET, 32'h83, 32'h02);
        rd(8'h10, d, r);
        check(r, pmwc_pkg::RESP_SLVERR);
        check(d, 32'h0);
        $display("test regs done");
    endtask : test_regs
    task automatic test_clocks();
        logic sub;
        for (int c = 0; c < 9; c++) begin
            wr(pmwc_pkg::MODE_OFFSET, {24'h0, 3'(c), 3'h0, 1'b1, c == 8});
            repeat (8) @(posedge aclk);
            sub = (c < 2);
            check({sys_clk_is_sub, high_osc_enable, high_div_taps_enable}, {sub, !sub, !sub});
            if (!sub) check(high_div_log2, (c == 8) ? 3'h0 : 3'(8 - c));
        end
        $display("test clocks done");
    endtask : test_clocks
    task automatic test_modes();
        logic [9:0] tbl [5] = '{10'h008, 10'h091, 10'h051, 10'h29B, 10'h3A7};
        logic [9:0] e;
        int c0, r0;
        logic [31:0] d;
        logic [1:0] r;
        wr(pmwc_pkg::WAKE_OFFSET, 32'hFF);
        for (int i = 0; i < 5; i++) begin
            e = tbl[i];
            wr(pmwc_pkg::CTRL_OFFSET, {24'h0, e[8], 5'h0, e[7], e[6]});
            wr(pmwc_pkg::MODE_OFFSET, {24'h0, 6'h0, e[9], 1'b1});
            c0 = i_pmwc_cpu_model.clr_cnt;
            r0 = i_pmwc_cpu_model.resume_cnt;
            i_pmwc_cpu_model.run_halt();
            repeat (3) @(posedge aclk);
            check({cpu_halted, sys_clk_enable, time_base_clk_enable, sub_clk_enable}, {1'b1, e[2:0]});
            if (i == 0) check(wdt_clk_enable, 1'b0);
            check(i_pmwc_cpu_model.clr_cnt, c0 + 1);
            rchk(pmwc_pkg::STATUS_OFFSET, 32'h73, {e[5:3], 4'h1});
            port_fall(i);
            wait_wake();
            check(i_pmwc_cpu_model.resume_cnt, r0 + 1);
            if (i < 4) begin
                rchk(pmwc_pkg::MODE_OFFSET, 32'h04, 32'h0);
                for (int n = 0; n < 20 && d[2] !== 1'b1; n++) rd(pmwc_pkg::MODE_OFFSET, d, r);
                check(d[2], 1'b1);
                d = 32'h0;
            end
        end
        wr(pmwc_pkg::CTRL_OFFSET, 32'h02);
        $display("test modes done");
    endtask : test_modes
    task automatic irq_wake(input logic en, input logic full, input int vec);
        int v0, r0;
        v0 = i_pmwc_cpu_model.vector_cnt;
        r0 = i_pmwc_cpu_model.resume_cnt;
        irq_enable <= en ? 8'h04 : 8'h00;
        stack_full <= full;
        i_pmwc_cpu_model.run_halt();
        repeat (3) @(posedge aclk);
        irq_request <= 8'h04;
        wait_wake();
        check(i_pmwc_cpu_model.vector_cnt - v0, vec);
        check(i_pmwc_cpu_model.resume_cnt - r0, 1 - vec);
        irq_request <= 8'h00;
        stack_full <= 1'b0;
    endtask : irq_wake
    task automatic test_wake();
        int p0;
        p0 = i_pmwc_cpu_model.pcsp_cnt;
        wr(pmwc_pkg::WAKE_OFFSET, 32'h00);
        wr(pmwc_pkg::MODE_OFFSET, 32'h03);
        i_pmwc_cpu_model.run_halt();
        port_fall(0);
        repeat (20) @(posedge aclk);
        check(cpu_halted, 1'b1);
        @(posedge aclk);
        wdt_overflow <= 1'b1;
        @(posedge aclk);
        wdt_overflow <= 1'b0;
        wait_wake();
        check(i_pmwc_cpu_model.pcsp_cnt, p0 + 1);
        rchk(pmwc_pkg::STATUS_OFFSET, 32'h73, 32'h03);
        wr(pmwc_pkg::WAKE_OFFSET, 32'hFF);
        irq_request <= 8'h02;
        irq_enable <= 8'h02;
        i_pmwc_cpu_model.run_halt();
        repeat (20) @(posedge aclk);
        check(cpu_halted, 1'b1);
        port_fall(7);
        wait_wake();
        irq_request <= 8'h00;
        irq_wake(1'b1, 1'b0, 1);
        irq_wake(1'b0, 1'b0, 0);
        irq_wake(1'b1, 1'b1, 0);
        i_pmwc_cpu_model.run_clear();
        rchk(pmwc_pkg::STATUS_OFFSET, 32'h01, 32'h0);
        // crystal sub-clock: ready comes back only after the long count
        sub_is_crystal <= 1'b1;
        wr(pmwc_pkg::CTRL_OFFSET, 32'h00);
        wr(pmwc_pkg::MODE_OFFSET, 32'h01);
        i_pmwc_cpu_model.run_halt();
        repeat (3) @(posedge aclk);
        check(sub_clk_enable, 1'b0);
        port_fall(0);
        wait_wake();
        rchk(pmwc_pkg::MODE_OFFSET, 32'h08, 32'h00);
        repeat (20) @(posedge aclk);
        rchk(pmwc_pkg::MODE_OFFSET, 32'h08, 32'h08);
        $display("test wake done");
    endtask : test_wake
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        test_regs();
        test_clocks();
        test_modes();
        test_wake();
        conclude();
    end
endmodule : power_mode_wakeup_control_tb
